// *** design/mtccu_channel.v ***
// Compare/capture unit of one multi_timer channel with AXI4-Lite registers
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "mtccu_map.vh"

module mtccu_channel #(
    parameter DMA_CHANNELS = 16                // Implemented DMA channels
) (
    input  wire        mclk,                   // Channel clock
    input  wire        rst_n,                  // Synchronous reset, active low
    // AXI4-Lite slave
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Counter block
    input  wire [15:0] cnt_value,              // Current counter value
    input  wire [1:0]  cnt_mode,               // Count direction mode
    input  wire        cnt_max,                // Counter MAX pulse
    input  wire        cnt_zero,               // Counter ZERO pulse
    input  wire        cnt_wrap_zero,          // Counter reverted to 0x0000
    input  wire        cnt_wrap_max,           // Counter reverted to MAX
    input  wire        partner_match,          // MATCH of the paired unit
    output reg         cnt_reset_req,          // Reset counter pulse
    output reg         match,                  // MATCH pulse of this unit
    output reg         capture_evt,            // Capture taken pulse
    // Pins
    input  wire        capture_pin,            // External capture input
    output wire        wave_out,               // Waveform output
    output reg  [15:0] dma_req                 // DMA request pulses
);

    // Registers
    // Software-visible registers, the compare buffer behind the value
    // register, and the edge-detect history of both trigger sources
    reg  [15:0] ctl_q;                         // Control register
    reg  [15:0] val_q;                         // Compare/capture value
    reg  [15:0] dma_en_q;                      // Limit DMA enables
    reg  [15:0] cbuf_q;                        // Compare buffer
    reg         val_new_q;                     // Written, not yet loaded
    reg         wave_q;                        // Waveform, active high
    reg         pin_s1_q;                      // Sync stage one
    reg         pin_s2_q;                      // Sync stage two
    reg         pin_prev_q;                    // Previous trigger level
    reg         soft_prev_q;                   // Previous software level
    // AXI holding: a write address or data beat that arrives
    // before its partner waits here until both are present
    reg         aw_q;                          // Address beat held
    reg         w_q;                           // Data beat held
    reg  [11:0] awaddr_q;                      // Held write address
    reg  [31:0] wdata_q;                       // Held write data
    reg  [3:0]  wstrb_q;                       // Held byte strobes

    // Control fields; the capture-only fields are decoded here but
    // only take effect in capture mode, and the waveform fields only
    // in comparator mode

    wire        cap_mode  = ctl_q[`MTCCU_F_MODE];
    wire [2:0]  buf_mode  = ctl_q[`MTCCU_F_BUF_HI:`MTCCU_F_BUF_LO];
    wire [1:0]  src_sel   = ctl_q[`MTCCU_F_SRC_HI:`MTCCU_F_SRC_LO];
    wire [1:0]  edge_sel  = ctl_q[`MTCCU_F_EDGE_HI:`MTCCU_F_EDGE_LO];
    wire [2:0]  wave_mode = ctl_q[`MTCCU_F_WAVE_HI:`MTCCU_F_WAVE_LO];
    wire        pair      = ctl_q[`MTCCU_F_PAIR];
    wire        down      = (cnt_mode == `MTCCU_CNT_DOWN);

    // Write path: take address and data in either order
    // Ready drops while a beat is held or a response is pending, so
    // only one write is in flight; the register update happens at
    // the edge where both beats are known, which is also the edge
    // that raises the write response
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire aw_have = aw_q | (s_axi_awvalid & s_axi_awready);
    wire w_have  = w_q | (s_axi_wvalid & s_axi_wready);
    wire [11:0] wa = aw_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wd = w_q ? wdata_q : s_axi_wdata;
    wire [3:0]  ws = w_q ? wstrb_q : s_axi_wstrb;
    wire        wr_go = aw_have & w_have & !s_axi_bvalid;
    wire        wr_ctl = wr_go && (wa[11:2] == `MTCCU_OFF_CTL >> 2);
    wire        wr_val = wr_go && (wa[11:2] == `MTCCU_OFF_VAL >> 2);
    wire        wr_dma = wr_go && (wa[11:2] == `MTCCU_OFF_DMAEN >> 2);
    wire        wr_ok  = wr_ctl | wr_val | wr_dma;

    // Byte-lane merge of a 16-bit register
    // Only strobes 1 and 0 matter; the upper half of the bus word
    // has no register behind it and is dropped
    function [15:0] mtccu_merge;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  strb;
        begin
            mtccu_merge = {strb[1] ? data[15:8] : old[15:8],
                           strb[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    // Mask of implemented DMA channels; unimplemented ones do nothing
    wire [16:0] dma_lim  = (17'h1_0000 >> (16 - DMA_CHANNELS)) - 17'h0_0001;
    wire [15:0] dma_mask = dma_lim[15:0];

    // Control write keeps the reserved bit at zero
    wire [15:0] ctl_new = mtccu_merge(ctl_q, wd, ws) & `MTCCU_CTL_WMASK;

    // Capture trigger
    // Pin level: straight from the pin in asynchronous mode, or from
    // the second synchroniser stage in synchronous mode. The software
    // level is bit 0 of the source selector, so moving it between
    // 2 and 3 looks like an edge. Source code 1 never triggers.
    wire pin_lvl  = ctl_q[`MTCCU_F_SYNC] ? pin_s2_q : capture_pin;
    wire soft_lvl = src_sel[0];
    wire src_pin  = (src_sel == 2'h0);
    wire src_soft = src_sel[1];
    wire trig_lvl = src_soft ? soft_lvl : pin_lvl;
    wire trig_prv = src_soft ? soft_prev_q : pin_prev_q;
    wire t_rise   = trig_lvl & !trig_prv;
    wire t_fall   = !trig_lvl & trig_prv;
    wire t_edge   = (edge_sel[0] & t_rise) | (edge_sel[1] & t_fall);
    wire cap_now  = cap_mode & (src_pin | src_soft) & t_edge;

    // Comparison against the buffered value
    // Only live in comparator mode; the registered copy of this
    // term is the one-cycle MATCH pulse
    wire eq = !cap_mode && (cnt_value == cbuf_q);

    // Buffer load timing
    // Decides at which edge the written value moves into the compare
    // buffer. Mode 0 loads at the edge after the write; the others
    // wait for a counter event. Reserved codes 5 to 7 never load,
    // and capture mode never loads.
    reg  load;
    always @* begin
        load = 1'b0;
        if (!cap_mode) begin
            case (buf_mode)
                3'h0: load = val_new_q;
                3'h1: load = down ? cnt_zero :
                    (cnt_mode == `MTCCU_CNT_UP) ? cnt_max :
                    (cnt_max | cnt_zero);
                3'h2: load = eq;
                3'h3: load = down ? cnt_wrap_max :
                    (cnt_mode == `MTCCU_CNT_UP) ? cnt_wrap_zero :
                    (eq | cnt_wrap_zero);
                3'h4: load = eq;
                default: load = 1'b0;
            endcase
        end
    end

    // Set and reset events for the waveform
    // own_m is this unit's match, limit is the event that plays the
    // opposite role: MAX or ZERO alone, or the partner match when the
    // pair mode bit is set. any_m lets either match of the pair act
    // in the one-sided modes.
    wire own_m  = eq;
    wire limit  = pair ? partner_match :
                  (down ? cnt_zero : cnt_max);
    wire any_m  = own_m | (pair & partner_match);

    // Next waveform level. Where two events meet in one cycle the
    // roles give no order: toggle modes let the limit win, set/reset
    // modes let the match win, and toggle mode 4 in pair mode
    // cancels when both matches come together.
    reg  wave_d;
    always @* begin
        wave_d = wave_q;
        case (wave_mode)
            3'h0: wave_d = ctl_q[`MTCCU_F_SOFT];
            3'h1: if (any_m) wave_d = 1'b1;
            3'h2: if (limit) wave_d = 1'b0;
                  else if (own_m) wave_d = !wave_q;
            3'h3: if (own_m) wave_d = 1'b1;
                  else if (limit) wave_d = 1'b0;
            3'h4: if (own_m ^ (pair & partner_match))
                      wave_d = !wave_q;
            3'h5: if (any_m) wave_d = 1'b0;
            3'h6: if (limit) wave_d = 1'b1;
                  else if (own_m) wave_d = !wave_q;
            3'h7: if (own_m) wave_d = 1'b0;
                  else if (limit) wave_d = 1'b1;
            default: wave_d = wave_q;
        endcase
    end

    // Capture ignores all waveform controls, polarity included; the
    // waveform state is frozen there and the pin shows it active
    // high. In comparator mode the polarity bit inverts the output.
    // Switching modes can therefore move the pin by itself, which a
    // user must allow for when reusing a unit.
    wire pol_eff = ctl_q[`MTCCU_F_POL] & !cap_mode;
    assign wave_out = wave_q ^ pol_eff;

    // Registers, capture and waveform state
    // All event outputs are registered one cycle after the inputs that
    // cause them, except a pin capture in synchronous mode, which comes
    // three cycles after the pin. Capture beats a software write of the value
    // register in the same cycle, so a captured count is never lost
    // to a late write; the write then has no effect.
    always @(posedge mclk) begin
        if (!rst_n) begin
            ctl_q       <= `MTCCU_RST_CTL;
            val_q       <= `MTCCU_RST_VAL;
            dma_en_q    <= `MTCCU_RST_DMAEN;
            cbuf_q      <= `MTCCU_RST_VAL;
            val_new_q   <= 1'b0;
            wave_q      <= 1'b0;
            pin_s1_q    <= 1'b0;
            pin_s2_q    <= 1'b0;
            pin_prev_q  <= 1'b0;
            soft_prev_q <= 1'b0;
            match       <= 1'b0;
            capture_evt <= 1'b0;
            cnt_reset_req <= 1'b0;
            dma_req     <= 16'h0000;
        end else begin
            // Synchroniser and edge history run in every mode
            pin_s1_q    <= capture_pin;
            pin_s2_q    <= pin_s1_q;
            pin_prev_q  <= pin_lvl;
            soft_prev_q <= soft_lvl;
            // Register writes from the bus
            if (wr_ctl)
                ctl_q <= ctl_new;
            if (wr_dma)
                dma_en_q <= mtccu_merge(dma_en_q, wd, ws);
            // Capture beats a software write of the value register
            if (cap_now)
                val_q <= cnt_value;
            else if (wr_val)
                val_q <= mtccu_merge(val_q, wd, ws);
            // A new write wins over a pending load of the old value
            if (wr_val && !cap_mode)
                val_new_q <= 1'b1;
            else if (load)
                val_new_q <= 1'b0;
            // Buffer follows the value register at the load point
            if (load)
                cbuf_q <= val_q;
            // One-cycle event pulses
            match         <= eq;
            capture_evt   <= cap_now;
            cnt_reset_req <= eq && (buf_mode == 3'h4);
            // Waveform frozen while capturing
            if (!cap_mode)
                wave_q <= wave_d;
            dma_req <= (cnt_max | cnt_zero) ?
                (dma_en_q & dma_mask) : 16'h0000;
        end
    end

    // AXI4-Lite handshake state
    // Write response one cycle after both beats are known; read data
    // one cycle after the address is taken. Each answer stands until
    // its ready is seen. Unmapped addresses answer with SLVERR and
    // read zero. The status word shows the compare buffer.
    always @(posedge mclk) begin
        if (!rst_n) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MTCCU_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `MTCCU_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                aw_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_q <= 1'b1;
            end
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `MTCCU_RESP_OKAY : `MTCCU_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `MTCCU_RESP_OKAY;
                case (s_axi_araddr[11:2])
                    `MTCCU_OFF_CTL >> 2:   s_axi_rdata <= {16'h0000, ctl_q};
                    `MTCCU_OFF_VAL >> 2:   s_axi_rdata <= {16'h0000, val_q};
                    `MTCCU_OFF_DMAEN >> 2: s_axi_rdata <= {16'h0000, dma_en_q};
                    `MTCCU_OFF_STAT >> 2:  s_axi_rdata <= {16'h0000, cbuf_q};
                    // Unmapped word: zero data, error response
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `MTCCU_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// *** design/mtccu_map.vh ***
// Register map, field positions and reset values of the compare/capture unit
`ifndef MTCCU_MAP_VH
`define MTCCU_MAP_VH
`define MTCCU_OFF_CTL      12'h000
`define MTCCU_OFF_VAL      12'h004
`define MTCCU_OFF_DMAEN    12'h008
`define MTCCU_OFF_STAT     12'h00C
`define MTCCU_RST_CTL      16'h0000
`define MTCCU_RST_VAL      16'h0000
`define MTCCU_RST_DMAEN    16'h0000
`define MTCCU_F_SYNC       15
`define MTCCU_F_BUF_HI     14
`define MTCCU_F_BUF_LO     12
`define MTCCU_F_SRC_HI     11
`define MTCCU_F_SRC_LO     10
`define MTCCU_F_EDGE_HI    9
`define MTCCU_F_EDGE_LO    8
`define MTCCU_F_PAIR       6
`define MTCCU_F_SOFT       5
`define MTCCU_F_WAVE_HI    4
`define MTCCU_F_WAVE_LO    2
`define MTCCU_F_POL        1
`define MTCCU_F_MODE       0
`define MTCCU_CTL_WMASK    16'hFF7F
`define MTCCU_CNT_UP       2'h0
`define MTCCU_CNT_DOWN     2'h1
`define MTCCU_CNT_UPDN     2'h2
`define MTCCU_RESP_OKAY    2'h0
`define MTCCU_RESP_SLVERR  2'h2
`endif

// *** test/mtccu_channel_asserts.sv ***
// Port assertions for the compare/capture unit
`timescale 1ns/100ps
`default_nettype none
module mtccu_channel_asserts #(
    parameter DMA_CHANNELS = 16                 // Implemented DMA channels
) (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        cnt_max,
    input wire logic        cnt_zero,
    input wire logic        partner_match,
    input wire logic        cnt_reset_req,
    input wire logic        match,
    input wire logic        capture_evt,
    input wire logic        wave_out,
    input wire logic [15:0] dma_req
);
    // One clock domain, reset disables every check
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_DMA_CAUSE: assert property (dma_req != 16'h0000 |-> $past(cnt_max || cnt_zero)) else $error("dma request without limit event");
    AST_RESET_MATCH: assert property (cnt_reset_req |-> match) else $error("counter reset without match");
    AST_MODE_EXCL: assert property (!(match && capture_evt)) else $error("match and capture together");
    AST_WAVE_CAUSE: assert property ($changed(wave_out) |-> match || $past(match || partner_match || cnt_max || cnt_zero) || s_axi_bvalid || $past(s_axi_bvalid)) else $error("wave output moved without cause");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while response pending");
    AST_R_CAUSE: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready)) else $error("read data without request");
    // Main scenarios reached
    COV_MATCH: cover property (match);
    COV_CAPTURE: cover property (capture_evt);
    COV_DMA: cover property (dma_req != 16'h0000);
endmodule
bind mtccu_channel mtccu_channel_asserts #(.DMA_CHANNELS(DMA_CHANNELS)) u_chk (.*);
`default_nettype wire

// *** test/mtccu_pin_src.sv ***
// Model of the external capture pin source
`timescale 1ns/100ps
`default_nettype none
module mtccu_pin_src (
    input  wire logic mclk,
    output var logic  capture_pin
);
    // Idle line rests low
    initial capture_pin = 1'b0;
    // New level after a chosen number of cycles, prompt or slow
    task automatic drive(input logic lvl, input int dly);
        repeat (dly) @(posedge mclk);
        capture_pin <= lvl;
    endtask
endmodule
`default_nettype wire

// *** test/mtccu_channel_bench.sv ***
// Self-checking bench for the compare/capture unit
`timescale 1ns/100ps
`default_nettype none
`include "mtccu_map.vh"
module mtccu_channel_bench;
    logic        mclk = 1'b0, rst_n = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire logic   s_axi_arready, s_axi_rvalid;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    logic [15:0] cnt_value = 16'hFFFF;      // Parked away from the buffer
    logic [1:0]  cnt_mode = 2'h0;
    logic        cnt_max = 1'b0, cnt_zero = 1'b0, partner_match = 1'b0;
    logic        cnt_wrap_zero = 1'b0, cnt_wrap_max = 1'b0;
    wire logic   cnt_reset_req, match, capture_evt, capture_pin, wave_out;
    wire logic [15:0] dma_req;
    logic [31:0] rv;                        // Last read data
    logic [1:0]  resp_q;                    // Last response code
    logic [15:0] dma_q;                     // Requests after a limit pulse
    int          failures = 0, tests_run = 0, n_match = 0, n_rst = 0;
    int          n_cap = 0;

    mtccu_channel #(.DMA_CHANNELS(16)) u_dut (.*);
    mtccu_pin_src u_pin (.mclk, .capture_pin);

    // 5 ns clock
    always #2.5 mclk = ~mclk;
    // Count match, counter reset and capture pulses
    always @(posedge mclk) if (match === 1'b1) n_match <= n_match + 1;
    always @(posedge mclk) if (cnt_reset_req === 1'b1) n_rst <= n_rst + 1;
    always @(posedge mclk) if (capture_evt === 1'b1) n_cap <= n_cap + 1;

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Compare and tally
    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // Write: address and data together, bready held until bvalid
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        resp_q = s_axi_bresp;
    endtask
    // Read one word, compare it
    task automatic rc(input logic [11:0] a, input logic [31:0] e,
                      input string nm);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rv = s_axi_rdata;
        resp_q = s_axi_rresp;
        chk(nm, e, rv);
    endtask
    // Counter sits on a value for one cycle
    task automatic hit(input logic [15:0] v);
        @(posedge mclk);
        cnt_value <= v;
        @(posedge mclk);
        cnt_value <= 16'hFFFF;
        tick(3);
    endtask
    // One MAX (z=0) or ZERO (z=1) pulse, requests caught after it
    task automatic lim(input logic z);
        @(posedge mclk);
        cnt_max <= !z;
        cnt_zero <= z;
        @(posedge mclk);
        cnt_max <= 1'b0;
        cnt_zero <= 1'b0;
        @(posedge mclk);
        dma_q = dma_req;
        tick(2);
    endtask
    // One partner match pulse
    task automatic pm;
        @(posedge mclk);
        partner_match <= 1'b1;
        @(posedge mclk);
        partner_match <= 1'b0;
        tick(3);
    endtask
    task automatic stop_test;
        $display("comparisons %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        tick(20000);
        failures++;
        stop_test();
    end
    // Main sequence
    initial begin
        tick(10);
        rst_n <= 1'b1;
        rc(`MTCCU_OFF_CTL, 32'h0, "ctl reset");
        rc(`MTCCU_OFF_VAL, 32'h0, "value reset");
        rc(`MTCCU_OFF_DMAEN, 32'h0, "dma reset");
        rc(12'h010, 32'h0, "unmapped data");
        chk("unmapped resp", `MTCCU_RESP_SLVERR, resp_q);
        wr(12'h010, 16'h0001);
        chk("wr unmapped", `MTCCU_RESP_SLVERR, resp_q);
        wr(`MTCCU_OFF_CTL, 16'hFFFF);
        chk("wr okay", `MTCCU_RESP_OKAY, resp_q);
        rc(`MTCCU_OFF_CTL, 32'hFF7F, "ctl mask");
        wr(`MTCCU_OFF_CTL, 16'h0004);
        wr(`MTCCU_OFF_VAL, 16'h0010);
        rc(`MTCCU_OFF_STAT, 32'h0010, "load now");
        hit(16'h0010);
        chk("set", 1, wave_out);
        chk("match pulses", 1, n_match);
        wr(`MTCCU_OFF_CTL, 16'h001C);
        hit(16'h0010);
        chk("reset on match", 0, wave_out);
        lim(1'b0);
        chk("set on max", 1, wave_out);
        chk("dma off", 0, dma_q);
        cnt_mode <= `MTCCU_CNT_DOWN;
        hit(16'h0010);
        lim(1'b1);
        chk("set on zero", 1, wave_out);
        cnt_mode <= `MTCCU_CNT_UP;
        wr(`MTCCU_OFF_CTL, 16'h000C);
        lim(1'b0);
        chk("inactive on max", 0, wave_out);
        hit(16'h0010);
        chk("active on match", 1, wave_out);
        wr(`MTCCU_OFF_CTL, 16'h0022);
        tick(2);
        chk("inverted", 0, wave_out);
        wr(`MTCCU_OFF_CTL, 16'h0020);
        tick(2);
        chk("soft level", 1, wave_out);
        wr(`MTCCU_OFF_CTL, 16'h1000);
        wr(`MTCCU_OFF_VAL, 16'h0020);
        rc(`MTCCU_OFF_STAT, 32'h0010, "held");
        lim(1'b0);
        rc(`MTCCU_OFF_STAT, 32'h0020, "load at max");
        wr(`MTCCU_OFF_CTL, 16'h2000);
        wr(`MTCCU_OFF_VAL, 16'h0030);
        hit(16'h0020);
        rc(`MTCCU_OFF_STAT, 32'h0030, "load at match");
        wr(`MTCCU_OFF_DMAEN, 16'h0005);
        lim(1'b0);
        chk("dma", 16'h0005, dma_q);
        wr(`MTCCU_OFF_CTL, 16'h4000);
        wr(`MTCCU_OFF_VAL, 16'h0040);
        hit(16'h0030);
        rc(`MTCCU_OFF_STAT, 32'h0040, "load and reset");
        chk("counter reset", 1, n_rst);
        wr(`MTCCU_OFF_CTL, 16'h0048);
        hit(16'h0040);
        chk("pair toggle", 1, wave_out);
        pm();
        chk("pair reset", 0, wave_out);
        wr(`MTCCU_OFF_CTL, 16'h0050);
        pm();
        chk("pair invert", 1, wave_out);
        wr(`MTCCU_OFF_CTL, 16'h0054);
        pm();
        chk("pair inactive", 0, wave_out);
        wr(`MTCCU_OFF_CTL, 16'h0101);
        cnt_value <= 16'h1234;
        u_pin.drive(1'b1, 3);
        tick(6);
        rc(`MTCCU_OFF_VAL, 32'h1234, "pin rise");
        cnt_value <= 16'h2222;
        u_pin.drive(1'b0, 2);
        tick(6);
        rc(`MTCCU_OFF_VAL, 32'h1234, "no fall");
        wr(`MTCCU_OFF_CTL, 16'h0901);
        cnt_value <= 16'h0055;
        wr(`MTCCU_OFF_CTL, 16'h0D01);
        rc(`MTCCU_OFF_VAL, 32'h0055, "soft rise");
        cnt_value <= 16'h0077;
        wr(`MTCCU_OFF_CTL, 16'h8B01);
        tick(4);
        rc(`MTCCU_OFF_VAL, 32'h0077, "sync fall");
        wr(`MTCCU_OFF_CTL, 16'h8101);
        cnt_value <= 16'h0099;
        u_pin.drive(1'b1, 1);
        tick(1);
        cnt_value <= 16'h009A;
        tick(1);
        cnt_value <= 16'h009B;
        tick(4);
        rc(`MTCCU_OFF_VAL, 32'h009B, "sync pin delay");
        chk("capture pulses", 5, n_cap);
        stop_test();
    end
endmodule
`default_nettype wire
